// *** pkg/tlvs_map.svh ***
// Constants for the lower order VC sink: stream positions, pointer fields and counts.
`ifndef TLVS_MAP_SVH
`define TLVS_MAP_SVH
`define TLVS_COLS 5'd20
`define TLVS_TU12_PER_TUG2 2'd3
`define TLVS_MF_FRAMES 2'd3
`define TLVS_NDF_NORMAL 4'h6
`define TLVS_NDF_NEW 4'h9
`define TLVS_SS_VC2 2'h0
`define TLVS_SS_VC12 2'h2
`define TLVS_SS_VC11 2'h3
`define TLVS_PTR_MAX_VC2 10'h1ab
`define TLVS_PTR_MAX_VC12 10'h08b
`define TLVS_PTR_MAX_VC11 10'h067
`define TLVS_AIS_ACCEPT 4'd3
`define TLVS_PTR_ACCEPT 4'd3
`define TLVS_LOP_COUNT 4'd8
`define TLVS_AIS_WORD 16'hffff
`define TLVS_ALL_ONES 8'hff
`endif

// *** pkg/tlvs_pkg.sv ***
// Types shared by the lower order VC sink.
package tlvs_pkg;
    typedef enum logic [1:0] {
        TLVS_VC2 = 2'b00,
        TLVS_VC12 = 2'b01,
        TLVS_VC11 = 2'b10
    } tlvs_variant_e;
    typedef enum logic [1:0] {
        TLVS_NORM = 2'b00,
        TLVS_AIS = 2'b01,
        TLVS_LOP = 2'b10
    } tlvs_pi_state_e;
endpackage

// *** hw/tlvs_sink.sv ***
// Lower order VC sink: timeslot extraction, pointer interpretation and defect handling.
`include "tlvs_map.svh"
module tlvs_sink (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_link_ck,
    input wire logic [7:0] i_link_d,
    input wire logic i_link_fs,
    input wire logic i_link_mfs,
    input wire logic i_incoming_trail_signal_fail,
    input wire logic i_function_activate,
    input wire logic i_ais_fault_report_enable,
    input wire logic [1:0] i_variant,
    input wire logic [4:0] i_ts_l,
    input wire logic [1:0] i_ts_m,
    output logic [7:0] o_client_data_out,
    output logic o_client_valid,
    output logic o_client_fs,
    output logic o_server_signal_fail_out,
    output logic o_alarm_indication_fault_cause,
    output logic o_pointer_loss_fault_cause
);
    // Two-stage synchronisers for everything arriving on the link.
    logic [11:0] sync1_reg;
    logic [11:0] sync2_reg;
    logic ck_prev_reg;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_reg <= 12'h000;
            sync2_reg <= 12'h000;
            ck_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {i_incoming_trail_signal_fail, i_link_mfs, i_link_fs, i_link_ck, i_link_d};
            sync2_reg <= sync1_reg;
            ck_prev_reg <= sync2_reg[8];
        end
    end
    wire [7:0] byte_d = sync2_reg[7:0];
    wire ck_s = sync2_reg[8];
    wire fs_s = sync2_reg[9];
    wire mfs_s = sync2_reg[10];
    wire tsf_s = sync2_reg[11];
    wire strobe = ck_s & ~ck_prev_reg;

    // Position within the frame: column of the TUG-2 and TU-12 group.
    logic [4:0] col_reg;
    logic [1:0] grp_reg;
    logic [1:0] phase_reg;
    logic first_reg;
    wire [4:0] col_cur = fs_s ? 5'd0 : col_reg;
    wire [1:0] grp_cur = fs_s ? 2'd0 : grp_reg;
    wire [1:0] phase_cur = mfs_s ? 2'd0 : (fs_s ? phase_reg + 2'd1 : phase_reg);
    wire first_cur = fs_s | first_reg;
    wire col_wrap = (col_cur == `TLVS_COLS - 5'd1);
    wire [4:0] col_next = col_wrap ? 5'd0 : col_cur + 5'd1;
    wire [1:0] grp_next = !col_wrap ? grp_cur :
        ((grp_cur == `TLVS_TU12_PER_TUG2 - 2'd1) ? 2'd0 : grp_cur + 2'd1);
    wire is_vc2 = (i_variant == tlvs_pkg::TLVS_VC2);
    wire col_hit = (col_cur == i_ts_l - 5'd1);
    wire grp_hit = is_vc2 | (grp_cur == i_ts_m - 2'd1);
    wire sel = strobe & col_hit & grp_hit;
    wire v_byte = sel & first_cur;
    wire v1_byte = v_byte & (phase_cur == 2'd0);
    wire v2_byte = v_byte & (phase_cur == 2'd1);
    wire pay_byte = sel & ~first_cur;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            col_reg <= 5'd0;
            grp_reg <= 2'd0;
            phase_reg <= 2'd0;
            first_reg <= 1'b0;
        end else if (strobe) begin
            col_reg <= col_next;
            grp_reg <= grp_next;
            phase_reg <= phase_cur;
            first_reg <= first_cur & ~sel;
        end
    end

    // Pointer word checks for the active variant.
    logic [7:0] v1_reg;
    wire [15:0] pword = {v1_reg, byte_d};
    wire [3:0] ndf = pword[15:12];
    wire [1:0] ss = pword[11:10];
    wire [9:0] pval = pword[9:0];
    wire [1:0] ss_exp = is_vc2 ? `TLVS_SS_VC2 :
        ((i_variant == tlvs_pkg::TLVS_VC12) ? `TLVS_SS_VC12 : `TLVS_SS_VC11);
    wire [9:0] pmax = is_vc2 ? `TLVS_PTR_MAX_VC2 :
        ((i_variant == tlvs_pkg::TLVS_VC12) ? `TLVS_PTR_MAX_VC12 : `TLVS_PTR_MAX_VC11);
    wire p_ais = (pword == `TLVS_AIS_WORD);
    wire p_fmt = (ss == ss_exp) && (pval <= pmax);
    wire p_norm = p_fmt && (ndf == `TLVS_NDF_NORMAL);
    wire p_new = p_fmt && (ndf == `TLVS_NDF_NEW);
    wire p_bad = !p_ais && !p_norm && !p_new;

    // Pointer interpreter state machine.
    tlvs_pkg::tlvs_pi_state_e state_reg;
    tlvs_pkg::tlvs_pi_state_e state_next;
    logic [9:0] ptr_reg;
    logic [9:0] ptr_next;
    logic [9:0] cand_reg;
    logic [9:0] cand_next;
    logic [3:0] cand_cnt_reg;
    logic [3:0] cand_cnt_next;
    logic [3:0] ais_cnt_reg;
    logic [3:0] ais_cnt_next;
    logic [3:0] bad_cnt_reg;
    logic [3:0] bad_cnt_next;

    always_comb begin
        state_next = state_reg;
        ptr_next = ptr_reg;
        cand_next = cand_reg;
        cand_cnt_next = cand_cnt_reg;
        ais_cnt_next = p_ais ? ais_cnt_reg + 4'd1 : 4'd0;
        bad_cnt_next = p_bad ? bad_cnt_reg + 4'd1 : 4'd0;
        if (p_norm) begin
            if (pval == cand_reg) begin
                cand_cnt_next = cand_cnt_reg + 4'd1;
            end else begin
                cand_next = pval;
                cand_cnt_next = 4'd1;
            end
        end else begin
            cand_cnt_next = 4'd0;
        end
        if (p_new) begin
            state_next = tlvs_pkg::TLVS_NORM;
            ptr_next = pval;
        end else if (cand_cnt_next == `TLVS_PTR_ACCEPT) begin
            state_next = tlvs_pkg::TLVS_NORM;
            ptr_next = pval;
        end else if (ais_cnt_next == `TLVS_AIS_ACCEPT) begin
            state_next = tlvs_pkg::TLVS_AIS;
        end else if (bad_cnt_next == `TLVS_LOP_COUNT) begin
            state_next = tlvs_pkg::TLVS_LOP;
        end
        if (ais_cnt_next > `TLVS_AIS_ACCEPT) begin
            ais_cnt_next = `TLVS_AIS_ACCEPT;
        end
        if (bad_cnt_next > `TLVS_LOP_COUNT) begin
            bad_cnt_next = `TLVS_LOP_COUNT;
        end
        if (cand_cnt_next > `TLVS_PTR_ACCEPT) begin
            cand_cnt_next = `TLVS_PTR_ACCEPT;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            v1_reg <= 8'h00;
            state_reg <= tlvs_pkg::TLVS_LOP;
            ptr_reg <= 10'h000;
            cand_reg <= 10'h000;
            cand_cnt_reg <= 4'd0;
            ais_cnt_reg <= 4'd0;
            bad_cnt_reg <= 4'd0;
        end else begin
            if (v1_byte) begin
                v1_reg <= byte_d;
            end
            if (v2_byte) begin
                state_reg <= state_next;
                ptr_reg <= ptr_next;
                cand_reg <= cand_next;
                cand_cnt_reg <= cand_cnt_next;
                ais_cnt_reg <= ais_cnt_next;
                bad_cnt_reg <= bad_cnt_next;
            end
        end
    end

    // Payload offset counter; zero is the byte right after V2.
    logic [9:0] idx_reg;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            idx_reg <= 10'h000;
        end else if (v2_byte) begin
            idx_reg <= 10'h000;
        end else if (pay_byte) begin
            idx_reg <= idx_reg + 10'h001;
        end
    end

    wire ais_defect = (state_reg == tlvs_pkg::TLVS_AIS);
    wire lop_defect = (state_reg == tlvs_pkg::TLVS_LOP);
    wire insert_act = ais_defect | lop_defect | tsf_s;
    wire fill_ones = insert_act | ~i_function_activate;
    wire vc_start = pay_byte & (idx_reg == ptr_reg) & (state_reg == tlvs_pkg::TLVS_NORM);
    wire [7:0] data_next = fill_ones ? `TLVS_ALL_ONES : byte_d;
    wire ais_cause = i_function_activate & ais_defect & ~tsf_s & i_ais_fault_report_enable;
    wire lop_cause = i_function_activate & lop_defect & ~tsf_s;

    // Outputs are registered; data follows the next link byte, far inside 1 ms.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_client_data_out <= `TLVS_ALL_ONES;
            o_client_valid <= 1'b0;
            o_client_fs <= 1'b0;
            o_server_signal_fail_out <= 1'b1;
            o_alarm_indication_fault_cause <= 1'b0;
            o_pointer_loss_fault_cause <= 1'b0;
        end else begin
            if (pay_byte) begin
                o_client_data_out <= data_next;
            end else if (fill_ones) begin
                o_client_data_out <= `TLVS_ALL_ONES;
            end
            o_client_valid <= pay_byte;
            o_client_fs <= vc_start & ~fill_ones;
            o_server_signal_fail_out <= insert_act;
            o_alarm_indication_fault_cause <= ais_cause;
            o_pointer_loss_fault_cause <= lop_cause;
        end
    end
endmodule // tlvs_sink

// *** verif/tlvs_sink_props.sv ***
// Port assertions for the lower order VC sink.
module tlvs_sink_props (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_incoming_trail_signal_fail,
    input wire logic i_function_activate,
    input wire logic i_ais_fault_report_enable,
    input wire logic [7:0] o_client_data_out,
    input wire logic o_client_valid,
    input wire logic o_client_fs,
    input wire logic o_server_signal_fail_out,
    input wire logic o_alarm_indication_fault_cause,
    input wire logic o_pointer_loss_fault_cause
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire tsf = i_incoming_trail_signal_fail;
    wire act = i_function_activate;
    wire ssf = o_server_signal_fail_out;
    wire c_ais = o_alarm_indication_fault_cause;
    wire c_lop = o_pointer_loss_fault_cause;
    AST_TSF_FAIL: assert property (tsf [*6] |=> ssf)
        else $error("server fail missing under trail fail");
    AST_TSF_MASK: assert property (tsf [*6] |-> !c_ais && !c_lop)
        else $error("fault cause shown under trail fail");
    AST_LOP_SSF: assert property (c_lop |-> ssf)
        else $error("pointer loss without server fail");
    AST_AIS_SSF: assert property (c_ais |-> ssf)
        else $error("alarm cause without server fail");
    AST_AIS_OFF: assert property (!i_ais_fault_report_enable [*2] |-> !c_ais)
        else $error("alarm cause while reporting disabled");
    AST_IDLE: assert property (!act [*2] |-> o_client_data_out == 8'hff && !c_ais && !c_lop && !o_client_fs)
        else $error("inactive sink not idle");
    AST_FILL: assert property (ssf && $past(ssf) && o_client_valid |-> o_client_data_out == 8'hff)
        else $error("payload passed during fill");
    AST_FS_VALID: assert property (o_client_fs |-> o_client_valid)
        else $error("frame start without payload byte");
    AST_PULSE: assert property (o_client_valid |=> !o_client_valid [*8])
        else $error("payload strobes too close");
    cover property (o_client_fs);
    cover property (c_ais);
    cover property (c_lop && !tsf);
endmodule // tlvs_sink_props
bind tlvs_sink tlvs_sink_props tlvs_sink_props_inst (.*);

// *** verif/tlvs_tug2_src.sv ***
// Behavioural TUG2 stream source: link clock, bytes and frame marks.
module tlvs_tug2_src;
    timeunit 1ns;
    timeprecision 1ps;
    logic ck = 1'b0;
    logic [7:0] d = 8'h00;
    logic fs = 1'b0;
    logic mfs = 1'b0;
    // One multiframe; the first selected byte of each frame carries V1..V4.
    task automatic mframe(input logic [15:0] w, input int pos);
        #1;
        for (int ph = 0; ph < 4; ph++) begin
            for (int i = 0; i < 60; i++) begin
                d = (i == pos) ? ((ph == 0) ? w[15:8] : (ph == 1) ? w[7:0] : 8'h00)
                    : {ph[1:0], i[5:0]};
                fs = (i == 0);
                mfs = (i == 0) && (ph == 0);
                #24 ck = 1'b1;
                #24 ck = 1'b0;
            end
        end
        // The clock stands still between multiframes and the data no longer holds.
        d = ~d;
    endtask
endmodule // tlvs_tug2_src

// *** verif/tlvs_sink_test.sv ***
// Self-checking bench for the lower order VC sink.
module tlvs_sink_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic tsf = 1'b0;
    logic act = 1'b1;
    logic ais_en = 1'b0;
    logic [7:0] dat;
    logic val, cfs, ssf, c_ais, c_lop;
    logic [7:0] fs_dat = 8'h00;
    logic [1:0] variant = 2'h0;
    logic [1:0] ts_m = 2'd1;
    int vpos = 19;
    int fail_count = 0;
    int n_checks = 0;
    wire [7:0] stat = {5'h00, c_ais, c_lop, ssf};
    tlvs_tug2_src tlvs_tug2_src_inst();
    tlvs_sink tlvs_sink_inst (.i_clk(clk), .i_rstn(rstn), .i_link_ck(tlvs_tug2_src_inst.ck),
        .i_link_d(tlvs_tug2_src_inst.d), .i_link_fs(tlvs_tug2_src_inst.fs),
        .i_link_mfs(tlvs_tug2_src_inst.mfs), .i_incoming_trail_signal_fail(tsf),
        .i_function_activate(act), .i_ais_fault_report_enable(ais_en), .i_variant(variant),
        .i_ts_l(5'd20), .i_ts_m(ts_m), .o_client_data_out(dat), .o_client_valid(val),
        .o_client_fs(cfs), .o_server_signal_fail_out(ssf),
        .o_alarm_indication_fault_cause(c_ais), .o_pointer_loss_fault_cause(c_lop));
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (cfs) fs_dat <= dat;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic run(input logic [15:0] w, input int n);
        repeat (n) tlvs_tug2_src_inst.mframe(w, vpos);
        tick(6);
    endtask
    initial begin
        tick(8);
        rstn <= 1'b1;
        tick(4);
        check(stat, 8'h03);
        check(dat, 8'hff);
        run(16'h9000, 1);
        check(stat, 8'h00);
        check(fs_dat, 8'h67);
        tsf <= 1'b1;
        run(16'h6000, 1);
        check(stat, 8'h01);
        check(dat, 8'hff);
        tsf <= 1'b0;
        act <= 1'b0;
        run(16'h6000, 1);
        check(stat, 8'h00);
        check(dat, 8'hff);
        act <= 1'b1;
        run(16'h6000, 1);
        check(dat, 8'hfb);
        run(16'hffff, 3);
        check(stat, 8'h01);
        ais_en <= 1'b1;
        tick(4);
        check(stat, 8'h05);
        run(16'h6c00, 8);
        check(stat, 8'h03);
        run(16'h9000, 1);
        check(stat, 8'h00);
        // Second TU-12 of the group: a VC-2 style word must be refused, then a VC-12 word taken.
        variant <= 2'h1;
        ts_m <= 2'd2;
        vpos = 39;
        run(16'h9000, 8);
        check(stat, 8'h03);
        run(16'h9800, 1);
        check(stat, 8'h00);
        report_and_stop();
    end
endmodule // tlvs_sink_test
